// ==== src/pcix_sec_cap_pkg.sv ====
// Package with offsets, field positions and reset values of the capability block
package pcix_sec_cap_pkg;
  localparam logic [7:0] OFS_GRANT_LATENCY = 8'h7C;
  localparam logic [7:0] OFS_CAP_STATUS = 8'h80;
  localparam logic [7:0] CAP_ID_VALUE = 8'h07;
  localparam logic [7:0] NEXT_CAP_VALUE = 8'h90;
  localparam logic [7:0] MIN_GRANT_RESET = 8'h00;
  localparam logic [7:0] MAX_LATENCY_RESET = 8'h00;
  localparam int BIT_WIDE_BUS = 16;
  localparam int BIT_FAST_CAPABLE = 17;
  localparam int BIT_COMPLETION_DISCARDED = 18;
  localparam int BIT_UNEXPECTED_COMPLETION = 19;
  localparam int BIT_COMPLETION_OVERRUN = 20;
  localparam int BIT_REQUEST_DELAYED = 21;
  localparam int FREQ_LSB = 22;
  localparam int FREQ_MSB = 24;
  localparam logic [2:0] FREQ_CONVENTIONAL = 3'h0;
  localparam logic [2:0] FREQ_66 = 3'h1;
  localparam logic [2:0] FREQ_133 = 3'h2;
  localparam logic [2:0] FREQ_RESET = 3'h0;
endpackage : pcix_sec_cap_pkg

// ==== src/pcix_secondary_capability_regs.sv ====
// Secondary grant/latency, capability header and secondary status registers
//
// Overview of operation
// - Bits 23:16 at 7Ch give the needed burst period, read-only, reset zero.
// - Bits 31:24 at 7Ch give the needed access rate, read-only, reset zero.
// - The grant and latency bytes mean something only in forward mode.
// - The low byte at 80h reads 07h as the capability identifier.
// - Bits 15:8 at 80h read 90h, the link to power management.
// - Status bit 16 always reads zero, no 64-bit secondary interface.
// - Bit 17 shows 133 MHz capability: one in forward, zero in reverse mode.
// - Bit 18 sets on a discarded split completion in forward mode only.
// - Bit 19 sets on a split completion for the bridge's own ID in reverse.
// - Bit 20 sets when a split completion is cut short by a full buffer.
// - Bit 21 sets when a split request is held by the commitment limit.
// - Bits 24:22 give the secondary clock code 000, 001 or 010.
// - In reverse mode the clock code reads 000, reset value 000.
`timescale 1ns/100ps
`default_nettype none
module pcix_secondary_capability_regs
#(
  parameter logic [7:0] MIN_GRANT = pcix_sec_cap_pkg::MIN_GRANT_RESET,
  parameter logic [7:0] MAX_LATENCY = pcix_sec_cap_pkg::MAX_LATENCY_RESET
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic reverse_mode,
  input wire logic [2:0] secondary_clock_code,
  input wire logic completion_discarded,
  input wire logic own_id_completion,
  input wire logic completion_overrun,
  input wire logic request_delayed,
  input wire logic cfg_read,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_offset,
  input wire logic [3:0] cfg_byte_enable,
  input wire logic [31:0] cfg_write_data,
  output logic [31:0] cfg_read_data
);
  import pcix_sec_cap_pkg::*;

  // ***************************************************
  // Strap capture and clock code
  // ***************************************************
  logic reverse_sync1;
  logic reverse_sync2;
  logic reverse;
  logic [2:0] code_sync1;
  logic [2:0] code_sync2;
  logic [2:0] freq_code;
  wire [2:0] next_freq_code = reverse_sync2 ? 3'h0 : code_sync2;
  always_ff @(posedge clock)
  begin
    reverse_sync1 <= reverse_mode;
    reverse_sync2 <= reverse_sync1;
    code_sync1 <= secondary_clock_code;
    code_sync2 <= code_sync1;
  end
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      reverse <= 1'b0;
      freq_code <= FREQ_RESET;
    end
    else
    begin
      reverse <= reverse_sync2;
      freq_code <= next_freq_code;
    end
  end

  // ***************************************************
  // Event synchronisers and status flags
  // ***************************************************
  logic [3:0] event_sync1;
  logic [3:0] event_sync2;
  logic [3:0] event_sync3;
  wire [3:0] event_raw = {request_delayed, completion_overrun,
    own_id_completion, completion_discarded};
  wire [3:0] event_rise = event_sync2 & ~event_sync3;
  always_ff @(posedge clock)
  begin
    event_sync1 <= event_raw;
    event_sync2 <= event_sync1;
    event_sync3 <= event_sync2;
  end
  wire status_write = cfg_write && cfg_offset == OFS_CAP_STATUS &&
    cfg_byte_enable[2];
  wire [3:0] clear_bits = status_write ?
    cfg_write_data[BIT_REQUEST_DELAYED:BIT_COMPLETION_DISCARDED] : 4'h0;
  wire [3:0] flag_enable = {1'b1, 1'b1, reverse, ~reverse};
  wire [3:0] flags;
  status_flag_if flag_port [4] ();
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : flag_bank
      assign flag_port[g].event_pulse = event_rise[g];
      assign flag_port[g].clear_pulse = clear_bits[g];
      assign flag_port[g].enable = flag_enable[g];
      assign flags[g] = flag_port[g].flag;
      sticky_status_flag flag_unit
      (
        .clock(clock),
        .resetn(resetn),
        .port(flag_port[g])
      );
    end
  endgenerate

  // ***************************************************
  // Read data
  // ***************************************************
  wire [7:0] grant_value = reverse ? 8'h00 : MIN_GRANT;
  wire [7:0] latency_value = reverse ? 8'h00 : MAX_LATENCY;
  wire [15:0] status_word = {7'h00, freq_code, flags, ~reverse, 1'b0};
  wire [31:0] word_7c = {latency_value, grant_value, 16'h0000};
  wire [31:0] word_80 = {status_word, NEXT_CAP_VALUE, CAP_ID_VALUE};
  wire [31:0] next_read_data = !cfg_read ? cfg_read_data :
    cfg_offset == OFS_GRANT_LATENCY ? word_7c :
    cfg_offset == OFS_CAP_STATUS ? word_80 : 32'h0000_0000;
  always_ff @(posedge clock)
  begin
    if (!resetn)
      cfg_read_data <= 32'h0000_0000;
    else
      cfg_read_data <= next_read_data;
  end

  // ***************************************************
  // Checks
  // ***************************************************
  cap_header_a: assert property (@(posedge clock) disable iff (!resetn)
    cfg_read && cfg_offset == OFS_CAP_STATUS |=>
    cfg_read_data[15:0] == 16'h9007)
    else $error("capability header wrong");
  reserved_zero_a: assert property (@(posedge clock) disable iff (!resetn)
    cfg_read |=> cfg_read_data[31:25] == 7'h00 || !$past(cfg_offset ==
    OFS_CAP_STATUS))
    else $error("reserved bits set");
  wide_bus_a: assert property (@(posedge clock) disable iff (!resetn)
    cfg_read && cfg_offset == OFS_CAP_STATUS |=> !cfg_read_data[16])
    else $error("64-bit bit set");
  fast_cap_a: assert property (@(posedge clock) disable iff (!resetn)
    cfg_read && cfg_offset == OFS_CAP_STATUS |=>
    cfg_read_data[17] == !$past(reverse))
    else $error("133 MHz bit wrong");
  reverse_freq_a: assert property (@(posedge clock) disable iff (!resetn)
    reverse_sync2 |=> freq_code == 3'h0)
    else $error("clock code in reverse mode");
  discard_fwd_a: assert property (@(posedge clock) disable iff (!resetn)
    event_rise[0] && !reverse |=> flags[0])
    else $error("discard not flagged");
  own_id_a: assert property (@(posedge clock) disable iff (!resetn)
    event_rise[1] && reverse |=> flags[1])
    else $error("own ID completion not flagged");
  overrun_a: assert property (@(posedge clock) disable iff (!resetn)
    event_rise[2] |=> flags[2])
    else $error("overrun not flagged");
  delayed_a: assert property (@(posedge clock) disable iff (!resetn)
    event_rise[3] |=> flags[3])
    else $error("delayed request not flagged");
  grant_reverse_a: assert property (@(posedge clock) disable iff (!resetn)
    reverse && cfg_read && cfg_offset == OFS_GRANT_LATENCY |=>
    cfg_read_data[31:16] == 16'h0000)
    else $error("grant bytes in reverse mode");

  // ***************************************************
  // Read path checks
  // ***************************************************
  read_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    !cfg_read |=> $stable(cfg_read_data))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (@(posedge clock) disable iff (!resetn)
    cfg_read && cfg_offset != OFS_GRANT_LATENCY &&
    cfg_offset != OFS_CAP_STATUS |=> cfg_read_data == 32'h0000_0000)
    else $error("unmapped offset read nonzero");
  grant_forward_a: assert property (@(posedge clock) disable iff (!resetn)
    !reverse && cfg_read && cfg_offset == OFS_GRANT_LATENCY |=>
    cfg_read_data[31:16] == {MAX_LATENCY, MIN_GRANT})
    else $error("grant bytes wrong in forward mode");
  grant_low_a: assert property (@(posedge clock) disable iff (!resetn)
    cfg_read && cfg_offset == OFS_GRANT_LATENCY |=>
    cfg_read_data[15:0] == 16'h0000)
    else $error("low half at 7C nonzero");
  freq_read_a: assert property (@(posedge clock) disable iff (!resetn)
    cfg_read && cfg_offset == OFS_CAP_STATUS |=>
    cfg_read_data[FREQ_MSB:FREQ_LSB] == $past(freq_code))
    else $error("clock code read wrong");
  flags_read_a: assert property (@(posedge clock) disable iff (!resetn)
    cfg_read && cfg_offset == OFS_CAP_STATUS |=>
    cfg_read_data[BIT_REQUEST_DELAYED:BIT_COMPLETION_DISCARDED] ==
    $past(flags))
    else $error("status flags read wrong");

  // ***************************************************
  // Clock code, mode and reset value checks
  // ***************************************************
  freq_forward_a: assert property (@(posedge clock) disable iff (!resetn)
    !reverse_sync2 |=> freq_code == $past(code_sync2))
    else $error("clock code not passed in forward mode");
  discard_reverse_a: assert property (@(posedge clock) disable iff (!resetn)
    reverse |=> !flags[0])
    else $error("discard flag set in reverse mode");
  own_id_forward_a: assert property (@(posedge clock) disable iff (!resetn)
    !reverse |=> !flags[1])
    else $error("own ID flag set in forward mode");
  reset_values_a: assert property (@(posedge clock)
    !resetn |=> cfg_read_data == 32'h0000_0000 && flags == 4'h0 &&
    freq_code == FREQ_RESET)
    else $error("reset values wrong");

  // ***************************************************
  // Clear path checks and cover points
  // ***************************************************
  clear_discard_a: assert property (@(posedge clock) disable iff (!resetn)
    status_write && cfg_write_data[BIT_COMPLETION_DISCARDED] &&
    !event_rise[0] |=> !flags[0])
    else $error("discard flag not cleared");
  clear_own_id_a: assert property (@(posedge clock) disable iff (!resetn)
    status_write && cfg_write_data[BIT_UNEXPECTED_COMPLETION] &&
    !event_rise[1] |=> !flags[1])
    else $error("own ID flag not cleared");
  clear_overrun_a: assert property (@(posedge clock) disable iff (!resetn)
    status_write && cfg_write_data[BIT_COMPLETION_OVERRUN] &&
    !event_rise[2] |=> !flags[2])
    else $error("overrun flag not cleared");
  clear_delayed_a: assert property (@(posedge clock) disable iff (!resetn)
    status_write && cfg_write_data[BIT_REQUEST_DELAYED] &&
    !event_rise[3] |=> !flags[3])
    else $error("delayed flag not cleared");
  lane_ignored_a: assert property (@(posedge clock) disable iff (!resetn)
    cfg_write && !cfg_byte_enable[2] && flags[2] |=> flags[2])
    else $error("write without byte lane 2 cleared a flag");
  offset_ignored_a: assert property (@(posedge clock) disable iff (!resetn)
    cfg_write && cfg_offset != OFS_CAP_STATUS && flags[3] |=>
    flags[3])
    else $error("write to other offset cleared a flag");
  zero_kept_a: assert property (@(posedge clock) disable iff (!resetn)
    status_write && !cfg_write_data[BIT_COMPLETION_OVERRUN] &&
    flags[2] |=> flags[2])
    else $error("writing zero cleared a flag");
  set_over_clear_a: assert property (@(posedge clock) disable iff (!resetn)
    event_rise[3] && clear_bits[3] |=> flags[3])
    else $error("clear beat a new event");
  code_cover: cover property (@(posedge clock) disable iff (!resetn)
    freq_code == FREQ_133 && cfg_read && cfg_offset == OFS_CAP_STATUS);
  discard_cover: cover property (@(posedge clock) disable iff (!resetn)
    flags[0] ##1 status_write ##1 !flags[0]);
  overrun_cover: cover property (@(posedge clock) disable iff (!resetn)
    event_rise[2] && clear_bits[2]);
  reverse_cover: cover property (@(posedge clock) disable iff (!resetn)
    reverse && flags[1]);
endmodule : pcix_secondary_capability_regs
`default_nettype wire

// ==== src/status_flag_if.sv ====
// Interface carrying event, clear and flag for one sticky status bit
`timescale 1ns/100ps
`default_nettype none
interface status_flag_if;
  logic event_pulse;
  logic clear_pulse;
  logic enable;
  logic flag;
  modport owner (input event_pulse, input clear_pulse, input enable,
    output flag);
  modport user (output event_pulse, output clear_pulse, output enable,
    input flag);
endinterface : status_flag_if
`default_nettype wire

// ==== src/sticky_status_flag.sv ====
// One write-one-to-clear sticky status flag
`timescale 1ns/100ps
`default_nettype none
module sticky_status_flag
(
  input wire logic clock,
  input wire logic resetn,
  status_flag_if.owner port
);
  logic held;
  wire next_held = port.enable &
    (port.event_pulse | (held & ~port.clear_pulse));
  always_ff @(posedge clock)
  begin
    if (!resetn)
      held <= 1'b0;
    else
      held <= next_held;
  end
  assign port.flag = held;
  set_wins_a: assert property (@(posedge clock) disable iff (!resetn)
    port.enable && port.event_pulse |=> port.flag)
    else $error("event lost");
  zero_disabled_a: assert property (@(posedge clock) disable iff (!resetn)
    !port.enable |=> !port.flag)
    else $error("flag set while disabled");
  clear_works_a: assert property (@(posedge clock) disable iff (!resetn)
    port.clear_pulse && !port.event_pulse |=> !port.flag)
    else $error("clear ignored");
endmodule : sticky_status_flag
`default_nettype wire

// ==== tb/secondary_event_source.sv ====
// Far-side model: bridge-mode strap, clock code and split events
`timescale 1ns/100ps
`default_nettype none
module secondary_event_source
(
  input wire logic clock,
  output logic reverse_mode,
  output logic [2:0] secondary_clock_code,
  output logic [3:0] events
);
  initial
  begin
    reverse_mode = 1'b0;
    secondary_clock_code = 3'h0;
    events = 4'h0;
  end
  // Strap and code move only at the falling edge
  task set_mode(input logic rev, input logic [2:0] code);
    @(negedge clock);
    reverse_mode = rev;
    secondary_clock_code = code;
  endtask : set_mode
  // Events held high two cycles, then released low
  task fire(input logic [3:0] which);
    @(negedge clock);
    events = which;
    repeat (2) @(negedge clock);
    events = 4'h0;
  endtask : fire
endmodule : secondary_event_source
`default_nettype wire

// ==== tb/tb_pcix_secondary_capability_regs.sv ====
// Self-checking bench for the secondary capability registers
`timescale 1ns/100ps
`default_nettype none
module tb_pcix_secondary_capability_regs;
  import pcix_sec_cap_pkg::*;
  logic clock, resetn, cfg_read, cfg_write, reverse_mode;
  logic [7:0] cfg_offset;
  logic [3:0] cfg_byte_enable, events, flags, ev, mask;
  logic [31:0] cfg_write_data, cfg_read_data, d;
  logic [2:0] secondary_clock_code, code;
  int errors, samples_checked, seed, cycles = 0, mode, pass;
  secondary_event_source i_secondary_event_source (.clock(clock),
    .reverse_mode(reverse_mode),
    .secondary_clock_code(secondary_clock_code), .events(events));
  pcix_secondary_capability_regs i_pcix_secondary_capability_regs (
    .clock(clock), .resetn(resetn), .reverse_mode(reverse_mode),
    .secondary_clock_code(secondary_clock_code),
    .completion_discarded(events[0]), .own_id_completion(events[1]),
    .completion_overrun(events[2]), .request_delayed(events[3]),
    .cfg_read(cfg_read), .cfg_write(cfg_write), .cfg_offset(cfg_offset),
    .cfg_byte_enable(cfg_byte_enable), .cfg_write_data(cfg_write_data),
    .cfg_read_data(cfg_read_data));
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  task check(input string name, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task cfg_rd(input logic [7:0] ofs, output logic [31:0] data);
    @(negedge clock);
    cfg_read = 1'b1;
    cfg_offset = ofs;
    @(negedge clock);
    cfg_read = 1'b0;
    data = cfg_read_data;
  endtask : cfg_rd
  task cfg_wr(input logic [7:0] ofs, input logic [3:0] be,
    input logic [31:0] data);
    @(negedge clock);
    cfg_write = 1'b1;
    cfg_offset = ofs;
    cfg_byte_enable = be;
    cfg_write_data = data;
    @(negedge clock);
    cfg_write = 1'b0;
  endtask : cfg_wr
  function automatic logic [31:0] status(logic rev, logic [2:0] c,
    logic [3:0] f);
    return {7'h00, rev ? 3'h0 : c, f, ~rev, 1'b0, NEXT_CAP_VALUE,
      CAP_ID_VALUE};
  endfunction : status
  task results;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      results();
    end
  end
  initial
  begin
    seed = 38006;
    {resetn, cfg_read, cfg_write, cfg_offset} = '0;
    {cfg_byte_enable, cfg_write_data} = '0;
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    cfg_wr(OFS_GRANT_LATENCY, 4'hF, 32'hFFFFFFFF);
    cfg_rd(OFS_GRANT_LATENCY, d);
    check("grant_latency", d,
      {MAX_LATENCY_RESET, MIN_GRANT_RESET, 16'h0});
    cfg_rd(8'h78, d);
    check("unmapped", d, 32'h0);
    for (mode = 0; mode < 2; mode++)
      for (pass = 0; pass < 3; pass++)
      begin
        code = 3'($unsigned($random(seed)) % 3);
        i_secondary_event_source.set_mode(mode[0], code);
        repeat (4) @(negedge clock);
        flags = 4'h0;
        cfg_rd(OFS_CAP_STATUS, d);
        check("status_idle", d, status(mode[0], code, flags));
        cfg_rd(OFS_GRANT_LATENCY, d);
        check("grant_mode", d, mode[0] ? 32'h0 :
          {MAX_LATENCY_RESET, MIN_GRANT_RESET, 16'h0});
        ev = 4'($random(seed));
        i_secondary_event_source.fire(ev);
        repeat (4) @(negedge clock);
        flags = ev & (mode[0] ? 4'hE : 4'hD);
        cfg_rd(OFS_CAP_STATUS, d);
        check("status_event", d, status(mode[0], code, flags));
        cfg_wr(OFS_CAP_STATUS, 4'hB, 32'hFFFFFFFF);
        mask = 4'($random(seed));
        cfg_wr(OFS_CAP_STATUS, 4'hF, {10'h3FF, mask, 18'h3FFFF});
        flags = flags & ~mask;
        cfg_rd(OFS_CAP_STATUS, d);
        check("status_clear", d, status(mode[0], code, flags));
        cfg_wr(OFS_CAP_STATUS, 4'h4, 32'h003C0000);
      end
    results();
  end
endmodule : tb_pcix_secondary_capability_regs
`default_nettype wire
